// file: rtl/mrr_pkg.sv
// Package: widths, opcodes, reset values and carriers for the executor
package mrr_pkg;

  // Widths
  localparam int PC_W    = 13;
  localparam int ADDR_W  = 7;
  localparam int DATA_W  = 8;
  localparam int INSTR_W = 14;

  // Field positions inside an instruction word
  localparam int DEST_BIT   = 7;
  localparam int ADDR_LSB   = 0;
  localparam int LIT_LSB    = 0;
  localparam int OPC6_LSB   = 8;
  localparam int OPC4_LSB   = 10;

  // Opcodes
  localparam logic [5:0]         OPC_FILE_MOVE = 6'h08;
  localparam logic [5:0]         OPC_ROT_LEFT  = 6'h0D;
  localparam logic [5:0]         OPC_ROT_RIGHT = 6'h0C;
  localparam logic [3:0]         OPC_LIT_RET   = 4'hD;
  localparam logic [INSTR_W-1:0] WORD_NOP      = 14'h0000;
  localparam logic [INSTR_W-1:0] WORD_IRQ_RET  = 14'h0009;

  // Reset values
  localparam logic [DATA_W-1:0] W_RST  = 8'h00;
  localparam logic [PC_W-1:0]   PC_RST = 13'h0000;

  typedef enum logic [1:0] {ST_IDLE, ST_FILE, ST_RET} mrr_state_t;

  typedef enum logic [2:0] {
    OP_NOP, OP_MOVE, OP_ROTL, OP_ROTR, OP_IRQ_RET, OP_LIT_RET
  } mrr_op_t;

  typedef struct packed {
    logic globalIrqEnable;
    logic digitCarry;
    logic carry;
    logic zero;
  } mrr_status_t;

  localparam mrr_status_t STATUS_RST = '{1'b0, 1'b0, 1'b0, 1'b0};

endpackage : mrr_pkg

// file: rtl/mrr_file_mem.sv
// File register array with registered read data
`timescale 1ns/1ns
`default_nettype none
module mrr_file_mem #(
  parameter int ADDR_W = 7,
  parameter int DATA_W = 8
) (
  // Clock
  input  wire logic              sys_clk,
  // Read port
  input  wire logic [ADDR_W-1:0] rdAddr,
  output var  logic [DATA_W-1:0] rdData,
  // Write port
  input  wire logic              wrEn,
  input  wire logic [ADDR_W-1:0] wrAddr,
  input  wire logic [DATA_W-1:0] wrData
);

  logic [DATA_W-1:0] mem [2**ADDR_W];

  // Contents are not cleared by reset, as in a real register file
  // Plain always, so simulation may preload the array from outside
  always @(posedge sys_clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
    rdData <= mem[rdAddr];
  end

endmodule // mrr_file_mem
`default_nettype wire

// file: rtl/mrr_exec.sv
// Executor for move, no-op, return and rotate-through-carry instructions
//
// Summary of operation
// - Move file to W or back to file
// - Move updates zero only, others kept
// - Seven-bit file address, one destination bit
// - Interrupt return: PC from stack, enable set
// - Literal return loads W, flags unchanged
// - Literal return pops PC, two cycles
// - Rotate left through carry to destination
// - Rotate right through carry to destination
// - Rotates change carry flag only
`timescale 1ns/1ns
`default_nettype none
module mrr_exec
  import mrr_pkg::*;
(
  // Clock and reset
  input  wire logic               sys_clk,
  input  wire logic               rst,
  // Instruction stream
  input  wire logic               instrValid,
  input  wire logic [INSTR_W-1:0] instrWord,
  output var  logic               instrReady,
  output var  logic               done,
  // Return stack
  input  wire logic [PC_W-1:0]    stackTop,
  output var  logic               stackPop,
  // Core state
  output var  logic [DATA_W-1:0]  wReg,
  output var  mrr_status_t        status,
  output var  logic [PC_W-1:0]    pc
);

  typedef struct packed {
    mrr_state_t           state;
    mrr_op_t              op;
    logic [ADDR_W-1:0]    addr;
    logic                 dest;
    logic [DATA_W-1:0]    w;
    mrr_status_t          status;
    logic [PC_W-1:0]      pc;
    logic                 ready;
    logic                 done;
    logic                 pop;
  } mrr_core_t;

  localparam mrr_core_t CORE_RST = '{
    state: ST_IDLE, op: OP_NOP, addr: '0, dest: 1'b0, w: W_RST,
    status: STATUS_RST, pc: PC_RST, ready: 1'b1, done: 1'b0, pop: 1'b0
  };

  mrr_core_t s_r, s_nxt;

  logic [DATA_W-1:0] memRd;
  logic [ADDR_W-1:0] memRdAddr;
  logic              memWrEn;
  logic [DATA_W-1:0] result;
  logic              carryNxt;
  logic              accept;

  // Unlisted words fall back to a no-op so the stream never stalls
  function automatic mrr_op_t decode(input logic [INSTR_W-1:0] iw);
    logic [5:0] opc6;
    opc6 = iw[OPC6_LSB +: 6];
    if (iw[OPC4_LSB +: 4] == OPC_LIT_RET) begin
      return OP_LIT_RET;
    end
    if (iw == WORD_IRQ_RET) begin
      return OP_IRQ_RET;
    end
    case (opc6)
      OPC_FILE_MOVE: return OP_MOVE;
      OPC_ROT_LEFT:  return OP_ROTL;
      OPC_ROT_RIGHT: return OP_ROTR;
      default:       return OP_NOP;
    endcase
  endfunction

  function automatic logic isZero(input logic [DATA_W-1:0] v);
    return v == '0;
  endfunction

  assign accept = instrValid && s_r.ready;

  assign memRdAddr = instrWord[ADDR_LSB +: ADDR_W];

  mrr_file_mem #(
    .ADDR_W (ADDR_W),
    .DATA_W (DATA_W)
  ) u_mem (
    .sys_clk (sys_clk),
    .rdAddr  (memRdAddr),
    .rdData  (memRd),
    .wrEn    (memWrEn),
    .wrAddr  (s_r.addr),
    .wrData  (result)
  );

  always_comb begin
    s_nxt    = s_r;
    s_nxt.done = 1'b0;
    s_nxt.pop  = 1'b0;
    memWrEn  = 1'b0;
    result   = memRd;
    carryNxt = s_r.status.carry;
    unique case (s_r.op)
      OP_ROTL: begin
        result   = {memRd[DATA_W-2:0], s_r.status.carry};
        carryNxt = memRd[DATA_W-1];
      end
      OP_ROTR: begin
        result   = {s_r.status.carry, memRd[DATA_W-1:1]};
        carryNxt = memRd[0];
      end
      default: begin
        result   = memRd;
        carryNxt = s_r.status.carry;
      end
    endcase
    unique case (s_r.state)
      ST_IDLE: begin
        if (accept) begin
          s_nxt.op   = decode(instrWord);
          s_nxt.addr = instrWord[ADDR_LSB +: ADDR_W];
          s_nxt.dest = instrWord[DEST_BIT];
          unique case (decode(instrWord))
            OP_NOP: begin
              s_nxt.pc   = s_r.pc + 1'b1;
              s_nxt.done = 1'b1;
            end
            OP_MOVE, OP_ROTL, OP_ROTR: begin
              s_nxt.state = ST_FILE;
              s_nxt.ready = 1'b0;
            end
            OP_IRQ_RET: begin
              s_nxt.pc                     = stackTop;
              s_nxt.pop                    = 1'b1;
              s_nxt.status.globalIrqEnable = 1'b1;
              s_nxt.state                  = ST_RET;
              s_nxt.ready                  = 1'b0;
            end
            // literal into W, PC from stack
            OP_LIT_RET: begin
              s_nxt.w     = instrWord[LIT_LSB +: DATA_W];
              s_nxt.pc    = stackTop;
              s_nxt.pop   = 1'b1;
              s_nxt.state = ST_RET;
              s_nxt.ready = 1'b0;
            end
          endcase
        end
      end
      // Read data of the addressed register is valid here
      ST_FILE: begin
        if (s_r.dest) begin
          memWrEn = 1'b1;
        end else begin
          s_nxt.w = result;
        end
        // move sets zero from moved value
        if (s_r.op == OP_MOVE) begin
          s_nxt.status.zero = isZero(memRd);
        end else begin
          s_nxt.status.carry = carryNxt;
        end
        s_nxt.pc    = s_r.pc + 1'b1;
        s_nxt.done  = 1'b1;
        s_nxt.ready = 1'b1;
        s_nxt.state = ST_IDLE;
      end
      ST_RET: begin
        s_nxt.done  = 1'b1;
        s_nxt.ready = 1'b1;
        s_nxt.state = ST_IDLE;
      end
      default: begin
        s_nxt = CORE_RST;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_r <= CORE_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign instrReady = s_r.ready;
  assign done       = s_r.done;
  assign stackPop   = s_r.pop;
  assign wReg       = s_r.w;
  assign status     = s_r.status;
  assign pc         = s_r.pc;

  // Checks
  logic fileMove;
  logic fileRot;
  logic oldCarry;
  logic memMsb;
  logic memLsb;
  assign fileMove = s_r.state == ST_FILE && s_r.op == OP_MOVE;
  assign fileRot  = s_r.state == ST_FILE &&
                    (s_r.op == OP_ROTL || s_r.op == OP_ROTR);
  assign oldCarry = s_r.status.carry;
  assign memMsb   = memRd[DATA_W-1];
  assign memLsb   = memRd[0];

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence seq_take(logic [INSTR_W-1:0] w);
    accept && instrWord == w;
  endsequence
  sequence seq_take_lit;
    accept && instrWord[OPC4_LSB +: 4] == OPC_LIT_RET;
  endsequence
  sequence seq_two_cycle;
    !done && !instrReady ##1 done && instrReady;
  endsequence

  a_move_zero_flag: assert property (
    fileMove |=> status.zero == ($past(memRd) == 8'h00))
    else $error("zero flag wrong after file move");
  a_move_keeps_rest: assert property (
    fileMove |=> $stable(status.carry) && $stable(status.digitCarry))
    else $error("file move changed a flag other than zero");
  a_move_to_w: assert property (
    fileMove && !s_r.dest |=> wReg == $past(memRd))
    else $error("file move did not load W");
  a_file_back_w: assert property (
    s_r.state == ST_FILE && s_r.dest |-> memWrEn ##1 $stable(wReg))
    else $error("write-back to file disturbed W");
  a_rotl_carry_in: assert property (
    s_r.state == ST_FILE && s_r.op == OP_ROTL && !s_r.dest
      |=> wReg[0] == $past(oldCarry) && status.carry == $past(memMsb))
    else $error("rotate left carry path wrong");
  a_rotr_carry_in: assert property (
    s_r.state == ST_FILE && s_r.op == OP_ROTR && !s_r.dest
      |=> wReg[7] == $past(oldCarry) && status.carry == $past(memLsb))
    else $error("rotate right carry path wrong");
  a_rot_flags_kept: assert property (
    fileRot |=> $stable(status.zero) && $stable(status.digitCarry))
    else $error("rotate changed zero or digit carry");
  a_irq_ret_enable: assert property (
    seq_take(WORD_IRQ_RET)
      |=> status.globalIrqEnable && pc == $past(stackTop) && stackPop
          && $stable(status.zero) ##0 seq_two_cycle)
    else $error("interrupt return failed");
  a_lit_ret_two: assert property (
    seq_take_lit |=> pc == $past(stackTop) ##0 seq_two_cycle)
    else $error("literal return not two cycles");
  a_lit_ret_w: assert property (
    seq_take_lit |=> ##1 wReg == $past(instrWord[7:0], 2)
      && $stable(status))
    else $error("literal return W or flags wrong");
  a_nop_pc_step: assert property (
    seq_take(WORD_NOP) |=> done && pc == $past(pc) + 13'h0001
      && $stable(wReg) && $stable(status))
    else $error("no-op did more than step PC");

endmodule // mrr_exec
`default_nettype wire

// file: dv/mrr_exec_tb.sv
// Self-checking bench for the move, return and rotate executor
`timescale 1ns/1ns
`default_nettype none
module mrr_exec_tb
  import mrr_pkg::*;
;
  logic               sys_clk;
  logic               rst;
  logic               instrValid;
  logic [INSTR_W-1:0] instrWord;
  logic [PC_W-1:0]    stackTop;
  logic [PC_W-1:0]    pc;
  logic [PC_W-1:0]    mPc;
  logic               instrReady;
  logic               done;
  logic               stackPop;
  logic [DATA_W-1:0]  wReg;
  logic [DATA_W-1:0]  mW;
  mrr_status_t        status;
  mrr_status_t        mSt;
  logic [24:0]        noteQ[$];
  logic [DATA_W-1:0]  mFile [128];
  int                 errCount;
  int                 cmpCount;
  int                 seed;

  mrr_exec DUT (.sys_clk(sys_clk), .rst(rst), .instrValid(instrValid),
    .instrWord(instrWord), .instrReady(instrReady), .done(done),
    .stackTop(stackTop), .stackPop(stackPop), .wReg(wReg),
    .status(status), .pc(pc));

  always #10 sys_clk = ~sys_clk;

  task automatic chk(input logic [24:0] got, input logic [24:0] exp);
    cmpCount++;
    if (got !== exp) begin
      errCount++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic finish_test;
    $display("Counts: %0d compares, %0d errors", cmpCount, errCount);
    if (errCount == 0 && cmpCount > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic do_reset;
    rst = 1'b1;
    repeat (8) @(posedge sys_clk);
    #2;
    mW = W_RST;
    mSt = STATUS_RST;
    mPc = PC_RST;
    chk({wReg, status, pc}, {W_RST, STATUS_RST, PC_RST});
    chk(25'({instrReady, done, stackPop}), 25'h4);
    rst = 1'b0;
  endtask

  function automatic logic [6:0] addrOf(input int i);
    return (i < 2) ? 7'h00 : (i < 4) ? 7'h7F : 7'($random(seed));
  endfunction

  task automatic run(input logic [INSTR_W-1:0] w, input logic [PC_W-1:0] top);
    int                n;
    int                lat;
    logic              pop;
    logic              isFile;
    logic [ADDR_W-1:0] a;
    logic [DATA_W-1:0] r;
    n = 1;
    lat = 2;
    pop = 1'b0;
    isFile = 1'b1;
    a = w[ADDR_LSB +: ADDR_W];
    r = mFile[a];
    // Idle edge first, so no strobe is driven twice in one time step
    @(posedge sys_clk);
    #2;
    mPc = mPc + 13'h0001;
    // only zero, carry or the global interrupt enable may move
    if (w[13:8] === OPC_FILE_MOVE) begin
      mSt.zero = (r == 8'h00);
    end else if (w[13:8] === OPC_ROT_LEFT) begin
      r = {mFile[a][6:0], mSt.carry};
      mSt.carry = mFile[a][7];
    end else if (w[13:8] === OPC_ROT_RIGHT) begin
      r = {mSt.carry, mFile[a][7:1]};
      mSt.carry = mFile[a][0];
    end else begin
      isFile = 1'b0;
      if (w[13:10] === OPC_LIT_RET) begin
        mW = w[7:0];
        mPc = top;
        pop = 1'b1;
      end else if (w === WORD_IRQ_RET) begin
        mSt.globalIrqEnable = 1'b1;
        mPc = top;
        pop = 1'b1;
      end else begin
        lat = 1;
      end
    end
    if (isFile && w[DEST_BIT]) begin
      mFile[a] = r;
    end else if (isFile) begin
      mW = r;
    end
    noteQ.push_back({mW, mSt, mPc});
    instrValid = 1'b1;
    instrWord = w;
    stackTop = top;
    @(posedge sys_clk);
    #2;
    // Offer while busy must be refused
    instrValid = (lat == 2);
    instrWord = 14'($random(seed));
    stackTop = 13'($random(seed));
    chk(25'(stackPop), 25'(pop));
    while (done !== 1'b1 && n < 8) begin
      @(posedge sys_clk);
      #2;
      n++;
      instrValid = 1'b0;
    end
    chk(25'(n), 25'(lat));
  endtask

  always @(negedge sys_clk) begin
    if (done === 1'b1) begin
      if (noteQ.size() == 0) chk(25'(done), 25'h0);
      else chk({wReg, status, pc}, noteQ.pop_front());
    end
  end

  initial begin
    seed = 55050;
    sys_clk = 1'b0;
    rst = 1'b1;
    instrValid = 1'b0;
    instrWord = WORD_NOP;
    stackTop = PC_RST;
    errCount = 0;
    cmpCount = 0;
    // Known file contents; both ends of the range get fixed edge values
    for (int k = 0; k < 128; k++) begin
      mFile[k] = (k == 0) ? 8'h00 : (k == 127) ? 8'h81 : 8'($random(seed));
      DUT.u_mem.mem[k] = mFile[k];
    end
    do_reset;
    $display("Test reset done");
    for (int i = 0; i < 4; i++) begin
      run({OPC_LIT_RET, 2'(i), (i == 0) ? 8'h00 : (i == 3) ? 8'hFF :
           8'($random(seed))}, 13'($random(seed)));
    end
    run(WORD_IRQ_RET, 13'h1FFF);
    // Counter wraps from the top address
    run(WORD_NOP, PC_RST);
    run(14'h3ABC, PC_RST);
    run(14'h0008, PC_RST);
    run({OPC_LIT_RET, 2'h1, 8'h5A}, 13'h0123);
    $display("Test returns and no-ops done");
    for (int i = 0; i < 6; i++) begin
      run({OPC_FILE_MOVE, 1'b1, addrOf(i)}, PC_RST);
    end
    $display("Test file move done");
    do_reset;
    for (int i = 0; i < 6; i++) begin
      run({i[0] ? OPC_ROT_LEFT : OPC_ROT_RIGHT, 1'b1, addrOf(i)}, PC_RST);
    end
    run({OPC_FILE_MOVE, 1'b0, 7'h7F}, PC_RST);
    run({OPC_ROT_LEFT, 1'b0, 7'h00}, PC_RST);
    run({OPC_ROT_RIGHT, 1'b0, 7'h7F}, PC_RST);
    $display("Test rotates done");
    // Let the last done pulse reach the watcher before the queue is checked
    repeat (2) @(posedge sys_clk);
    chk(25'(noteQ.size()), 25'h0);
    finish_test;
  end

  // Whole run is under a hundred cycles
  initial begin
    #(20 * 3000);
    errCount++;
    finish_test;
  end
endmodule // mrr_exec_tb
`default_nettype wire
